/* logic/iwp_params.svh */
// Constants of the interrupt, watchdog, power-down and port-input decoder.
// Function
// - The interrupt-mask instruction clears the master flag, and interrupts go off one machine cycle later.
// - The interrupt-unmask instruction sets the master flag to one so that interrupts may be serviced.
// - Interrupts come on only one machine cycle after the interrupt-unmask instruction.
// - The watchdog stop-arm instruction does not stop the watchdog but lets a later restart stop it.
// - The power-down permit instruction lets a later power-down or deep power-down take effect.
// - The single-line read puts the line into accumulator bit 0 and clears the upper 3 bits.
// - The first-port read loads all 4 bits of the first port into the accumulator.
// - The second-port read loads all 4 bits of the second port into the accumulator.
// - The third-port read loads the 2 port bits into bits 1 and 0 and clears bits 3 and 2.
`ifndef IWP_PARAMS_SVH
`define IWP_PARAMS_SVH
// Register byte offsets.
`define IWP_OFS_CTRL 12'h000
`define IWP_OFS_STATUS 12'h004
`define IWP_OFS_ACC 12'h008
// Control register fields and reset value.
`define IWP_CTRL_EN 0
`define IWP_CTRL_RST 32'h0000_0001
`define IWP_CTRL_EN_RST 1'b1
// Status register fields.
`define IWP_ST_FLAG 0
`define IWP_ST_IRQEN 1
`define IWP_ST_WDARM 2
`define IWP_ST_PDPERM 3
// Opcodes printed for the decoded instructions.
`define IWP_OP_MASK 10'h004
`define IWP_OP_UNMASK 10'h005
`define IWP_OP_WDARM 10'h29c
`define IWP_OP_RDLINE 10'h26f
`define IWP_OP_RDP0 10'h260
`define IWP_OP_RDP1 10'h261
`define IWP_OP_RDP2 10'h262
// Reset values of the state bits.
`define IWP_FLAG_RST 1'b0
`define IWP_ACC_RST 4'h0
`endif

/* logic/iwp_pkg.sv */
// Types shared by the decoder of interrupt, watchdog, power and port ops.
package iwp_pkg;
   // One-hot code of the instruction decoded in a machine cycle.
   typedef enum logic [11:0] {
      IWP_NONE = 12'h001,
      IWP_MASK = 12'h002,
      IWP_UNMASK = 12'h004,
      IWP_WDARM = 12'h008,
      IWP_WDRST = 12'h010,
      IWP_PDPERM = 12'h020,
      IWP_PDOWN = 12'h040,
      IWP_PDDEEP = 12'h080,
      IWP_RDLINE = 12'h100,
      IWP_RDP0 = 12'h200,
      IWP_RDP1 = 12'h400,
      IWP_RDP2 = 12'h800
   } iwp_op_e;
endpackage

/* logic/iwp_decoder.sv */
// Decoder and executor of the interrupt, watchdog, power and port ops.
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "iwp_params.svh"
module iwp_decoder #(
   parameter logic [9:0] OP_WDRST = 10'h29e,
   parameter logic [9:0] OP_PDPERM = 10'h02d,
   parameter logic [9:0] OP_PDOWN = 10'h002,
   parameter logic [9:0] OP_PDDEEP = 10'h008
)(
   input wire logic i_clock,
   input wire logic i_reset,
   input wire logic i_mcycle,
   input wire logic i_exec,
   input wire logic [9:0] i_opcode,
   input wire logic i_line,
   input wire logic [3:0] i_first_port,
   input wire logic [3:0] i_second_port,
   input wire logic [1:0] i_third_port,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   output logic o_irq_master_flag,
   output logic o_irq_enable,
   output logic o_acc_load,
   output logic [3:0] o_acc_data,
   output logic o_watchdog_restart,
   output logic o_watchdog_stop,
   output logic o_power_down,
   output logic o_deep_power_down,
   output logic o_done
);

   ////////////////////////////////////////////////////////////////////
   // Pin synchronisers.

   logic line_m_r;
   logic line_s_r;
   logic [3:0] first_m_r;
   logic [3:0] first_s_r;
   logic [3:0] second_m_r;
   logic [3:0] second_s_r;
   logic [1:0] third_m_r;
   logic [1:0] third_s_r;

   // Two stages per port pin before the accumulator path sees it.
   always_ff @(posedge i_clock)
   begin
      line_m_r <= i_line;
      line_s_r <= line_m_r;
      first_m_r <= i_first_port;
      first_s_r <= first_m_r;
      second_m_r <= i_second_port;
      second_s_r <= second_m_r;
      third_m_r <= i_third_port;
      third_s_r <= third_m_r;
   end

   ////////////////////////////////////////////////////////////////////
   // Instruction decode.

   logic ctrl_en_r;
   logic take;
   iwp_pkg::iwp_op_e op;

   // An instruction counts once, in the cycle where its machine cycle ends.
   assign take = i_exec && i_mcycle && ctrl_en_r;

   // Map the opcode word onto the one-hot operation code.
   always_comb
   begin
      op = iwp_pkg::IWP_NONE;
      if (take)
      begin
         if (i_opcode == `IWP_OP_MASK)
            op = iwp_pkg::IWP_MASK;
         else if (i_opcode == `IWP_OP_UNMASK)
            op = iwp_pkg::IWP_UNMASK;
         else if (i_opcode == `IWP_OP_WDARM)
            op = iwp_pkg::IWP_WDARM;
         else if (i_opcode == OP_WDRST)
            op = iwp_pkg::IWP_WDRST;
         else if (i_opcode == OP_PDPERM)
            op = iwp_pkg::IWP_PDPERM;
         else if (i_opcode == OP_PDOWN)
            op = iwp_pkg::IWP_PDOWN;
         else if (i_opcode == OP_PDDEEP)
            op = iwp_pkg::IWP_PDDEEP;
         else if (i_opcode == `IWP_OP_RDLINE)
            op = iwp_pkg::IWP_RDLINE;
         else if (i_opcode == `IWP_OP_RDP0)
            op = iwp_pkg::IWP_RDP0;
         else if (i_opcode == `IWP_OP_RDP1)
            op = iwp_pkg::IWP_RDP1;
         else if (i_opcode == `IWP_OP_RDP2)
            op = iwp_pkg::IWP_RDP2;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Execution state.

   logic flag_r;
   logic flag_nxt;
   logic irqen_r;
   logic irqen_nxt;
   logic wdarm_r;
   logic wdarm_nxt;
   logic pdperm_r;
   logic pdperm_nxt;
   logic [3:0] acc_r;
   logic [3:0] acc_nxt;
   logic load_r;
   logic load_nxt;
   logic wdrst_r;
   logic wdrst_nxt;
   logic wdstop_r;
   logic wdstop_nxt;
   logic pd_r;
   logic pd_nxt;
   logic pdd_r;
   logic pdd_nxt;
   logic done_r;

   // Next values of the flags, the accumulator and the one-cycle pulses.
   always_comb
   begin
      flag_nxt = flag_r;
      irqen_nxt = irqen_r;
      wdarm_nxt = wdarm_r;
      pdperm_nxt = pdperm_r;
      acc_nxt = acc_r;
      load_nxt = 1'b0;
      wdrst_nxt = 1'b0;
      wdstop_nxt = 1'b0;
      pd_nxt = 1'b0;
      pdd_nxt = 1'b0;
      // The enable seen by interrupt logic trails the flag by one machine cycle.
      if (i_mcycle)
         irqen_nxt = flag_r;
      unique case (op)
         iwp_pkg::IWP_NONE:
            flag_nxt = flag_r;
         iwp_pkg::IWP_MASK:
            flag_nxt = 1'b0;
         iwp_pkg::IWP_UNMASK:
            flag_nxt = 1'b1;
         iwp_pkg::IWP_WDARM:
            wdarm_nxt = 1'b1;
         iwp_pkg::IWP_WDRST:
         begin
            wdrst_nxt = 1'b1;
            wdstop_nxt = wdarm_r;
            wdarm_nxt = 1'b0;
         end
         iwp_pkg::IWP_PDPERM:
            pdperm_nxt = 1'b1;
         iwp_pkg::IWP_PDOWN:
         begin
            pd_nxt = pdperm_r;
            pdperm_nxt = 1'b0;
         end
         iwp_pkg::IWP_PDDEEP:
         begin
            pdd_nxt = pdperm_r;
            pdperm_nxt = 1'b0;
         end
         iwp_pkg::IWP_RDLINE:
         begin
            acc_nxt = {3'h0, line_s_r};
            load_nxt = 1'b1;
         end
         iwp_pkg::IWP_RDP0:
         begin
            acc_nxt = first_s_r;
            load_nxt = 1'b1;
         end
         iwp_pkg::IWP_RDP1:
         begin
            acc_nxt = second_s_r;
            load_nxt = 1'b1;
         end
         iwp_pkg::IWP_RDP2:
         begin
            acc_nxt = {2'h0, third_s_r};
            load_nxt = 1'b1;
         end
      endcase
   end

   // Register the execution state; reset clears every flag and pulse.
   always_ff @(posedge i_clock)
   begin
      if (i_reset)
      begin
         flag_r <= `IWP_FLAG_RST;
         irqen_r <= `IWP_FLAG_RST;
         wdarm_r <= 1'b0;
         pdperm_r <= 1'b0;
         acc_r <= `IWP_ACC_RST;
         load_r <= 1'b0;
         wdrst_r <= 1'b0;
         wdstop_r <= 1'b0;
         pd_r <= 1'b0;
         pdd_r <= 1'b0;
         done_r <= 1'b0;
      end
      else
      begin
         flag_r <= flag_nxt;
         irqen_r <= irqen_nxt;
         wdarm_r <= wdarm_nxt;
         pdperm_r <= pdperm_nxt;
         acc_r <= acc_nxt;
         load_r <= load_nxt;
         wdrst_r <= wdrst_nxt;
         wdstop_r <= wdstop_nxt;
         pd_r <= pd_nxt;
         pdd_r <= pdd_nxt;
         done_r <= (op != iwp_pkg::IWP_NONE);
      end
   end

   assign o_irq_master_flag = flag_r;
   assign o_irq_enable = irqen_r;
   assign o_acc_load = load_r;
   assign o_acc_data = acc_r;
   assign o_watchdog_restart = wdrst_r;
   assign o_watchdog_stop = wdstop_r;
   assign o_power_down = pd_r;
   assign o_deep_power_down = pdd_r;
   assign o_done = done_r;

   ////////////////////////////////////////////////////////////////////
   // APB slave.

   logic [31:0] prdata_r;
   logic [31:0] prdata_nxt;
   logic ctrl_en_nxt;
   logic setup;
   logic hit;
   logic wr;

   assign setup = i_psel && !i_penable;
   assign hit = (i_paddr == `IWP_OFS_CTRL) || (i_paddr == `IWP_OFS_STATUS) || (i_paddr == `IWP_OFS_ACC);
   assign wr = i_psel && i_penable && i_pwrite && (i_paddr == `IWP_OFS_CTRL);

   // Read data is captured in the setup phase and shown in the access phase.
   always_comb
   begin
      prdata_nxt = prdata_r;
      ctrl_en_nxt = ctrl_en_r;
      if (setup)
      begin
         prdata_nxt = 32'h0000_0000;
         if (!i_pwrite && i_paddr == `IWP_OFS_CTRL)
            prdata_nxt[`IWP_CTRL_EN] = ctrl_en_r;
         else if (!i_pwrite && i_paddr == `IWP_OFS_STATUS)
         begin
            prdata_nxt[`IWP_ST_FLAG] = flag_r;
            prdata_nxt[`IWP_ST_IRQEN] = irqen_r;
            prdata_nxt[`IWP_ST_WDARM] = wdarm_r;
            prdata_nxt[`IWP_ST_PDPERM] = pdperm_r;
         end
         else if (!i_pwrite && i_paddr == `IWP_OFS_ACC)
            prdata_nxt[3:0] = acc_r;
      end
      if (wr)
         ctrl_en_nxt = i_pwdata[`IWP_CTRL_EN];
   end

   // Register the bus state.
   always_ff @(posedge i_clock)
   begin
      if (i_reset)
      begin
         prdata_r <= 32'h0000_0000;
         ctrl_en_r <= `IWP_CTRL_EN_RST;
      end
      else
      begin
         prdata_r <= prdata_nxt;
         ctrl_en_r <= ctrl_en_nxt;
      end
   end

   // Zero wait states; unmapped addresses answer with an error.
   assign o_pready = 1'b1;
   assign o_pslverr = i_psel && i_penable && !hit;
   assign o_prdata = prdata_r;

   ////////////////////////////////////////////////////////////////////
   // Checks.

   a_mask_clears_flag: assert property (@(posedge i_clock) disable iff (i_reset)
      op == iwp_pkg::IWP_MASK |=> !o_irq_master_flag)
      else $error("mask op did not clear the master flag");
   a_mask_delay: assert property (@(posedge i_clock) disable iff (i_reset)
      op == iwp_pkg::IWP_MASK && o_irq_enable |=> o_irq_enable)
      else $error("interrupts disabled too early");
   a_unmask_sets_flag: assert property (@(posedge i_clock) disable iff (i_reset)
      op == iwp_pkg::IWP_UNMASK |=> o_irq_master_flag)
      else $error("unmask op did not set the master flag");
   a_enable_follows: assert property (@(posedge i_clock) disable iff (i_reset)
      i_mcycle |=> o_irq_enable == $past(o_irq_master_flag))
      else $error("enable does not trail the flag by one machine cycle");
   a_wd_stop_armed: assert property (@(posedge i_clock) disable iff (i_reset)
      o_watchdog_stop |-> o_watchdog_restart && !wdarm_r)
      else $error("watchdog stopped without a restart or stayed armed");
   a_wd_arm_nostop: assert property (@(posedge i_clock) disable iff (i_reset)
      op == iwp_pkg::IWP_WDARM |=> !o_watchdog_stop ##1 wdarm_r)
      else $error("arm op stopped the watchdog or failed to arm");
   a_pd_permit: assert property (@(posedge i_clock) disable iff (i_reset)
      (op == iwp_pkg::IWP_PDOWN || op == iwp_pkg::IWP_PDDEEP) && !pdperm_r |=> !o_power_down && !o_deep_power_down)
      else $error("power-down entered without permit");
   a_rd_line: assert property (@(posedge i_clock) disable iff (i_reset)
      op == iwp_pkg::IWP_RDLINE |=> o_acc_load && o_acc_data == {3'h0, $past(line_s_r)})
      else $error("line read gave a wrong accumulator");
   a_rd_first: assert property (@(posedge i_clock) disable iff (i_reset)
      op == iwp_pkg::IWP_RDP0 |=> o_acc_data == $past(first_s_r))
      else $error("first port read gave a wrong accumulator");
   a_rd_second: assert property (@(posedge i_clock) disable iff (i_reset)
      op == iwp_pkg::IWP_RDP1 |=> o_acc_data == $past(second_s_r))
      else $error("second port read gave a wrong accumulator");
   a_rd_third: assert property (@(posedge i_clock) disable iff (i_reset)
      op == iwp_pkg::IWP_RDP2 |=> o_acc_data == {2'h0, $past(third_s_r)})
      else $error("third port read gave a wrong accumulator");
   a_one_cycle: assert property (@(posedge i_clock) disable iff (i_reset)
      take |=> o_done == ($past(op) != iwp_pkg::IWP_NONE) ##1 !o_done || $past(take))
      else $error("instruction did not finish in one cycle");

endmodule

/* tb/iwp_core_model.sv */
// Behavioural model of the core that hands decoded instructions to the block.
`timescale 1ns/1ps
module iwp_core_model (
   input wire logic i_clock,
   output logic o_mcycle,
   output logic o_exec,
   output logic [9:0] o_opcode
);
   logic [1:0] cnt_r = 2'h0;
   logic pend_valid = 1'b0;
   logic [9:0] pend_op = 10'h000;

   // Start quiet so the block sees no instruction before the first machine cycle.
   initial
   begin
      o_mcycle = 1'b0;
      o_exec = 1'b0;
      o_opcode = 10'h000;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // A machine cycle ends every fourth clock, and at most one word executes in it.
   always @(posedge i_clock)
   begin
      cnt_r <= cnt_r + 2'h1;
      o_mcycle <= (cnt_r == 2'h2);
      o_exec <= (cnt_r == 2'h2) && pend_valid;
      o_opcode <= ((cnt_r == 2'h2) && pend_valid) ? pend_op : ~o_opcode;
      if (cnt_r == 2'h2)
      begin
         pend_valid = 1'b0;
      end
   end

   // Queues one word and returns just after the edge at which the block takes it.
   task automatic issue(input logic [9:0] op);
      int n;
      // Step off the edge so the queued word never races the sampling process.
      #1;
      pend_op = op;
      pend_valid = 1'b1;
      n = 0;
      while (pend_valid && n < 8)
      begin
         @(posedge i_clock);
         #1;
         n++;
      end
      @(posedge i_clock);
      #1;
   endtask
endmodule

/* tb/tb.sv */
// Self-checking bench of the interrupt, watchdog, power-down and port-input decoder.
`timescale 1ns/1ps
`include "iwp_params.svh"
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin miscompares++; \
$display("Error %s expected %h seen %h", nm, exp, got); end end
module tb;
   localparam logic [9:0] OP_WDRST = 10'h29e;
   localparam logic [9:0] OP_PDPERM = 10'h02d;
   localparam logic [9:0] OP_PDOWN = 10'h002;
   localparam logic [9:0] OP_PDDEEP = 10'h008;
   logic i_clock = 1'b0;
   logic i_reset = 1'b1;
   logic i_line = 1'b0;
   logic [3:0] i_first_port = 4'h0;
   logic [3:0] i_second_port = 4'h0;
   logic [1:0] i_third_port = 2'h0;
   logic i_psel = 1'b0;
   logic i_penable = 1'b0;
   logic i_pwrite = 1'b0;
   logic [11:0] i_paddr = 12'h000;
   logic [31:0] i_pwdata = 32'h0000_0000;
   logic mcyc, exe, flag, irqen, ld, wdr, wds, pd, pdd, done, rdy, err;
   logic [9:0] opc;
   logic [3:0] acc;
   logic [31:0] rdata;
   logic [31:0] q;
   logic e;
   int miscompares = 0;
   int total_checks = 0;

   iwp_core_model core (.i_clock(i_clock), .o_mcycle(mcyc), .o_exec(exe), .o_opcode(opc));
   iwp_decoder #(.OP_WDRST(OP_WDRST), .OP_PDPERM(OP_PDPERM), .OP_PDOWN(OP_PDOWN), .OP_PDDEEP(OP_PDDEEP)) dut (
      .i_clock(i_clock), .i_reset(i_reset), .i_mcycle(mcyc), .i_exec(exe), .i_opcode(opc),
      .i_line(i_line), .i_first_port(i_first_port), .i_second_port(i_second_port), .i_third_port(i_third_port),
      .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
      .o_prdata(rdata), .o_pready(rdy), .o_pslverr(err), .o_irq_master_flag(flag), .o_irq_enable(irqen),
      .o_acc_load(ld), .o_acc_data(acc), .o_watchdog_restart(wdr), .o_watchdog_stop(wds),
      .o_power_down(pd), .o_deep_power_down(pdd), .o_done(done));

   // The clock toggles every half period of 25 ns.
   always #25 i_clock = ~i_clock;

   ////////////////////////////////////////////////////////////////////////////////
   // One APB transfer; the request stands until pready is seen high at an edge.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge i_clock);
      i_psel <= 1'b1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_clock);
      i_penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge i_clock);
         n++;
      end
      while (rdy !== 1'b1 && n < 16);
      `CHK("apb wait", 1'b1, rdy)
      if (rdy !== 1'b1)
      begin
         results();
      end
      q = rdata;
      e = err;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask

   // Executes one word and checks that the core saw it taken.
   task automatic op(input logic [9:0] c);
      core.issue(c);
      `CHK("issue wait", 1'b0, core.pend_valid)
      if (core.pend_valid !== 1'b0)
      begin
         results();
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
      begin
         $display("All checks passed");
      end
      else
      begin
         $display("Checks failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Register reset values, read-only status and the unmapped address.
   task automatic t_regs();
      apb(1'b0, `IWP_OFS_CTRL, 32'h0);
      `CHK("ctrl", `IWP_CTRL_RST, q)
      `CHK("ctrl err", 1'b0, e)
      apb(1'b1, `IWP_OFS_STATUS, 32'hffff_ffff);
      apb(1'b0, `IWP_OFS_STATUS, 32'h0);
      `CHK("status", 32'h0000_0000, q)
      apb(1'b0, `IWP_OFS_ACC, 32'h0);
      `CHK("acc reg", 32'h0000_0000, q)
      apb(1'b0, 12'h00c, 32'h0);
      `CHK("unmapped data", 32'h0000_0000, q)
      `CHK("unmapped err", 1'b1, e)
      $display("test regs finished");
   endtask

   // Flag moves at once, effective enable one machine cycle later.
   task automatic t_irq(input logic [9:0] c, input logic v);
      op(c);
      `CHK("flag", v, flag)
      `CHK("enable early", ~v, irqen)
      repeat (3) @(posedge i_clock);
      #1;
      `CHK("enable held", ~v, irqen)
      @(posedge i_clock);
      #1;
      `CHK("enable late", v, irqen)
      apb(1'b0, `IWP_OFS_STATUS, 32'h0);
      `CHK("status irq", {30'h0, v, v}, q)
      $display("test irq finished");
   endtask

   // Port reads in a row, upper bits cleared for narrow sources.
   task automatic t_reads();
      logic [9:0] ops [4];
      logic [3:0] exp [4];
      ops = '{`IWP_OP_RDP0, `IWP_OP_RDLINE, `IWP_OP_RDP1, `IWP_OP_RDP2};
      exp = '{4'ha, 4'h1, 4'h5, 4'h3};
      @(posedge i_clock);
      i_line <= 1'b1;
      i_first_port <= 4'ha;
      i_second_port <= 4'h5;
      i_third_port <= 2'h3;
      repeat (3) @(posedge i_clock);
      for (int i = 0; i < 4; i++)
      begin
         op(ops[i]);
         `CHK("acc load", 1'b1, ld)
         `CHK("acc data", exp[i], acc)
         `CHK("done", 1'b1, done)
         @(posedge i_clock);
         #1;
         `CHK("done pulse", 1'b0, done)
      end
      apb(1'b0, `IWP_OFS_ACC, 32'h0);
      `CHK("acc reg", 32'h0000_0003, q)
      $display("test reads finished");
   endtask

   // Restart stops the watchdog only after a stop-arm, and the arm is used up.
   task automatic t_wd();
      logic [9:0] ops [4];
      logic [3:0] stp;
      ops = '{OP_WDRST, `IWP_OP_WDARM, OP_WDRST, OP_WDRST};
      stp = 4'b0100;
      for (int i = 0; i < 4; i++)
      begin
         op(ops[i]);
         `CHK("wd restart", (i != 1), wdr)
         `CHK("wd stop", stp[i], wds)
         if (i == 1)
         begin
            apb(1'b0, `IWP_OFS_STATUS, 32'h0);
            `CHK("status armed", 32'h0000_0004, q)
         end
      end
      $display("test watchdog finished");
   endtask

   // Power-down ops act only after a permit, one permit per op.
   task automatic t_pd();
      logic [9:0] ops [6];
      logic [5:0] pde;
      logic [5:0] dpe;
      ops = '{OP_PDOWN, OP_PDPERM, OP_PDOWN, OP_PDPERM, OP_PDDEEP, OP_PDDEEP};
      pde = 6'b000100;
      dpe = 6'b010000;
      for (int i = 0; i < 6; i++)
      begin
         op(ops[i]);
         `CHK("power down", pde[i], pd)
         `CHK("deep power down", dpe[i], pdd)
         if (i == 1)
         begin
            apb(1'b0, `IWP_OFS_STATUS, 32'h0);
            `CHK("status permit", 32'h0000_0008, q)
         end
      end
      $display("test power finished");
   endtask

   // With the decoder disabled a read op leaves no trace.
   task automatic t_off();
      apb(1'b1, `IWP_OFS_CTRL, 32'h0);
      op(`IWP_OP_RDP0);
      `CHK("off load", 1'b0, ld)
      `CHK("off done", 1'b0, done)
      apb(1'b1, `IWP_OFS_CTRL, 32'h1);
      op(10'h3ff);
      `CHK("unknown load", 1'b0, ld)
      `CHK("unknown done", 1'b0, done)
      apb(1'b0, `IWP_OFS_CTRL, 32'h0);
      `CHK("ctrl back", 32'h0000_0001, q)
      $display("test disable finished");
   endtask

   // Main sequence: reset for 6 cycles, then every scenario.
   initial
   begin
      repeat (6) @(posedge i_clock);
      i_reset <= 1'b0;
      t_regs();
      t_irq(`IWP_OP_UNMASK, 1'b1);
      t_irq(`IWP_OP_MASK, 1'b0);
      t_reads();
      t_wd();
      t_pd();
      t_off();
      results();
   end
endmodule
